// file: flp_defs.svh
// Offsets, field positions, reset values and timing counts of the fault propagation block
`ifndef FLP_DEFS_SVH
`define FLP_DEFS_SVH

// Register indices; byte address is four times the index
`define FLP_IDX_PROP_EN 8'h02
`define FLP_IDX_CTRL 8'h10
`define FLP_IDX_STATUS 8'h11

// Propagation enable fields
`define FLP_PROP_W 6
`define FLP_PROP_RST 6'h3F
`define FLP_PROP_FIRST 1

// Control fields
`define FLP_CTRL_W 8
`define FLP_CTRL_RST 8'h00
`define FLP_CTRL_OT_CRIT 0
`define FLP_CTRL_UV_CRIT 1
`define FLP_CTRL_OV_EMERG 2
`define FLP_CTRL_LATCH_LO 3
`define FLP_CTRL_CLEAR 8

// Fault vector positions
`define FLP_F_OV 0
`define FLP_F_UV 1
`define FLP_F_OC 2
`define FLP_F_OT 3
`define FLP_F_TR 4
`define FLP_NFAULT 5

// Turn-off codes; lower is more severe, so a wired-AND line keeps the worst
`define FLP_OFF_EMERG 2'h0
`define FLP_OFF_CRIT 2'h1
`define FLP_OFF_SEQ 2'h3

// Timing
`define FLP_CLK_HZ 40000000
`define FLP_HICCUP_MS 130
`define FLP_HICCUP_CYC ((64'd`FLP_HICCUP_MS * 64'd`FLP_CLK_HZ) / 64'd1000)
`define FLP_CODE_SLOT 16

`endif

// file: flp_pkg.sv
// Types shared by the fault propagation block
package flp_pkg;
   typedef enum logic [2:0] {
      FLP_RUN,
      FLP_TX_CODE,
      FLP_RX_CODE,
      FLP_OFF_OWN,
      FLP_OFF_PEER,
      FLP_LATCHED
   } flp_state_e;
   typedef logic [1:0] flp_off_t;
endpackage

// file: flp_hiccup_timer.sv
// One-shot restart interval timer
module flp_hiccup_timer
   import flp_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter logic [CNT_W-1:0] CYCLES = 32'd5200000
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic start,
   output logic done,
   output logic busy
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic busy_ff;
   logic nxt_busy;
   logic done_ff;
   wire last = busy_ff && (cnt_ff == CYCLES - 1'b1);

   // Restart on start even when running, so the period begins at the fault
   assign nxt_cnt = start ? '0 : (busy_ff ? cnt_ff + 1'b1 : cnt_ff);
   assign nxt_busy = start | (busy_ff & ~last);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
         done_ff <= last & ~start;
      end
   end

   assign done = done_ff;
   assign busy = busy_ff;
endmodule

// file: flp_top.sv
// Fault propagation logic of a load converter on a shared open-drain fault line
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "flp_defs.svh"

// Notes on behaviour
// - Enabled fault type: faulting converter pulls the shared fault line low.
// - Seeing the line fall, a converter turns off with the sender's type.
// - Turn-off type is coded at the falling edge and decoded there.
// - Propagation disabled: converter turns off, line stays released high.
// - A group shares one wired fault line into one manager input.
// - Converters reached through linked groups switch off with the same type.
// - Propagation enable register at index 0x02, enables in bits 5..1.
// - Enable bits are read/write, 1 enables, reset to 1.
// - Under-voltage gives a sequenced turn-off using delay and slew settings; here it is critical when FLP_CTRL_UV_CRIT is set.
// - Non-latching fault: restart attempt every 130 ms until fault clears.
// - Hiccup period is 130 ms whatever turn-off delay is set.
// - Propagated under-voltage makes peers do a sequenced turn-off; here it is critical when FLP_CTRL_UV_CRIT is set.
// - Matching peers cycle off and on together at the hiccup period.
// - Three turn-off types: sequenced, critical, emergency low-side on.
module flp_top
   import flp_pkg::*;
#(
   parameter logic [31:0] HICCUP_CYCLES = 32'(`FLP_HICCUP_CYC),
   parameter int SLOT_CYC = `FLP_CODE_SLOT
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [`FLP_NFAULT-1:0] fault_active,
   input wire logic fault_line_in,
   output logic fault_line_out,
   output logic fault_line_oe,
   output logic conv_run,
   output logic seq_off,
   output logic hs_off,
   output logic ls_on
);
   localparam logic [7:0] SLOT = 8'(SLOT_CYC);
   // Line fall seen to converter off: full decode plus the state and output flops
   localparam int PEER_LO = 3 * SLOT_CYC + 1;
   localparam int PEER_HI = 3 * SLOT_CYC + 3;

   // Worst turn-off type among a set of active faults
   function automatic flp_off_t worst_type(input logic [`FLP_NFAULT-1:0] f,
                                           input logic [`FLP_CTRL_W-1:0] c);
      flp_off_t t;
      t = `FLP_OFF_SEQ;
      if (f[`FLP_F_OT] && c[`FLP_CTRL_OT_CRIT]) t = `FLP_OFF_CRIT;
      if (f[`FLP_F_UV] && c[`FLP_CTRL_UV_CRIT]) t = `FLP_OFF_CRIT;
      if (f[`FLP_F_TR] || f[`FLP_F_OC]) t = `FLP_OFF_CRIT;
      if (f[`FLP_F_OV]) t = c[`FLP_CTRL_OV_EMERG] ? `FLP_OFF_EMERG : `FLP_OFF_CRIT;
      return t;
   endfunction

   // Registers
   logic [`FLP_PROP_W-1:0] prop_en_ff;
   logic [`FLP_CTRL_W-1:0] ctrl_ff;
   logic [7:0] idx_ff;
   logic wr_ff;
   logic rd_ff;
   logic [31:0] hrdata_ff;

   // Line and state
   logic ok_s1_ff;
   logic ok_s2_ff;
   logic ok_d_ff;
   flp_state_e state_ff;
   flp_state_e nxt_state;
   logic [7:0] cnt_ff;
   flp_off_t type_ff;
   flp_off_t nxt_type;
   logic prop_ff;
   logic lat_ff;
   logic rx_b1_ff;
   logic rx_b0_ff;
   logic oe_ff;
   logic run_ff;
   logic seq_ff;
   logic hs_ff;
   logic ls_ff;
   logic tmr_done;
   logic tmr_busy;

   // Bus decode
   wire addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
   wire take = hsel && hready && htrans[1];
   wire [7:0] idx = haddr[9:2];
   wire wr_prop = wr_ff && (idx_ff == `FLP_IDX_PROP_EN);
   wire wr_ctrl = wr_ff && (idx_ff == `FLP_IDX_CTRL);
   wire clear_latch = wr_ctrl && hwdata[`FLP_CTRL_CLEAR];

   // Fault decisions
   wire [`FLP_NFAULT-1:0] prop_mask = prop_en_ff[`FLP_NFAULT:`FLP_PROP_FIRST];
   wire [`FLP_NFAULT-1:0] latch_mask = ctrl_ff[`FLP_CTRL_LATCH_LO +: `FLP_NFAULT];
   wire any_fault = |fault_active;
   wire fault_prop = |(fault_active & prop_mask);
   wire fault_lat = |(fault_active & latch_mask);
   wire ok_fell = ok_d_ff && !ok_s2_ff;
   // Slot of the count that the registered line drive will stand beside
   wire [7:0] nxt_cnt = (nxt_state != state_ff) ? 8'h00 : cnt_ff + 8'h01;
   wire [1:0] slot_no = (nxt_cnt < SLOT) ? 2'd0 : ((nxt_cnt < 2 * SLOT) ? 2'd1 : 2'd2);
   wire tx_end = (cnt_ff == 3 * SLOT - 1);
   wire rx_s1 = (cnt_ff == SLOT + SLOT / 2);
   wire rx_s2 = (cnt_ff == 2 * SLOT + SLOT / 2);
   wire rx_end = (cnt_ff == 3 * SLOT);
   wire [1:0] rx_code = {rx_b1_ff, rx_b0_ff};
   wire start_tmr = (state_ff == FLP_RUN) && any_fault;

   // Transmit pattern: start slot low, then code high bit, then low bit
   logic tx_drive;
   always_comb begin
      case (slot_no)
         2'd0: tx_drive = 1'b1;
         2'd1: tx_drive = ~type_ff[1];
         default: tx_drive = ~type_ff[0];
      endcase
   end

   // Next state; own fault takes priority over a line edge in the same cycle
   always_comb begin
      nxt_state = state_ff;
      nxt_type = type_ff;
      case (state_ff)
         FLP_RUN: begin
            if (any_fault) begin
               nxt_type = worst_type(fault_active, ctrl_ff);
               nxt_state = fault_prop ? FLP_TX_CODE : FLP_OFF_OWN;
            end else if (ok_fell) begin
               nxt_state = FLP_RX_CODE;
            end
         end
         FLP_TX_CODE: begin
            if (tx_end) nxt_state = FLP_OFF_OWN;
         end
         FLP_RX_CODE: begin
            if (rx_end) begin
               // Unused code read as critical: the safer of the two neighbours
               nxt_type = (rx_code == 2'h2) ? `FLP_OFF_CRIT : rx_code;
               nxt_state = FLP_OFF_PEER;
            end
         end
         FLP_OFF_OWN: begin
            if (tmr_done) nxt_state = lat_ff ? FLP_LATCHED : FLP_RUN;
         end
         FLP_OFF_PEER: begin
            if (ok_s2_ff) nxt_state = FLP_RUN;
         end
         FLP_LATCHED: begin
            if (clear_latch) nxt_state = FLP_RUN;
         end
         default: nxt_state = FLP_RUN;
      endcase
   end

   // Keep running while the code is decoded, so no stale style is applied
   wire nxt_run = (nxt_state == FLP_RUN) || (nxt_state == FLP_RX_CODE);
   wire nxt_oe = (nxt_state == FLP_TX_CODE) ? tx_drive :
                 ((nxt_state == FLP_OFF_OWN) || (nxt_state == FLP_LATCHED)) &&
                 (state_ff == FLP_RUN ? fault_prop : prop_ff);

   flp_hiccup_timer #(
      .CNT_W(32),
      .CYCLES(HICCUP_CYCLES)
   ) u_hiccup (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .start(start_tmr),
      .done(tmr_done),
      .busy(tmr_busy)
   );

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ok_s1_ff <= 1'b1;
         ok_s2_ff <= 1'b1;
         ok_d_ff <= 1'b1;
      end else begin
         ok_s1_ff <= fault_line_in;
         ok_s2_ff <= ok_s1_ff;
         ok_d_ff <= ok_s2_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= FLP_RUN;
         type_ff <= `FLP_OFF_SEQ;
         cnt_ff <= 8'h00;
         prop_ff <= 1'b0;
         lat_ff <= 1'b0;
         rx_b1_ff <= 1'b1;
         rx_b0_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         type_ff <= nxt_type;
         cnt_ff <= nxt_cnt;
         if (start_tmr) prop_ff <= fault_prop;
         if (start_tmr) lat_ff <= fault_lat;
         if (state_ff == FLP_RX_CODE && rx_s1) rx_b1_ff <= ok_s2_ff;
         if (state_ff == FLP_RX_CODE && rx_s2) rx_b0_ff <= ok_s2_ff;
      end
   end

   // Switch commands follow the turn-off type while off
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         oe_ff <= 1'b0;
         run_ff <= 1'b1;
         seq_ff <= 1'b0;
         hs_ff <= 1'b0;
         ls_ff <= 1'b0;
      end else begin
         oe_ff <= nxt_oe;
         run_ff <= nxt_run;
         seq_ff <= !nxt_run && (nxt_type == `FLP_OFF_SEQ);
         hs_ff <= !nxt_run && (nxt_type != `FLP_OFF_SEQ);
         ls_ff <= !nxt_run && (nxt_type == `FLP_OFF_EMERG);
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   wire [31:0] rd_val = (idx == `FLP_IDX_PROP_EN) ? {26'h0, prop_en_ff} :
                        (idx == `FLP_IDX_CTRL) ? {24'h0, ctrl_ff} :
                        (idx == `FLP_IDX_STATUS) ?
                        {22'h0, fault_active, tmr_busy, type_ff, oe_ff, ok_s2_ff} :
                        32'h0;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         idx_ff <= 8'h00;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         hrdata_ff <= 32'h0;
         prop_en_ff <= `FLP_PROP_RST;
         ctrl_ff <= `FLP_CTRL_RST;
      end else begin
         wr_ff <= take && hwrite && addr_ok;
         rd_ff <= take && !hwrite;
         if (take) idx_ff <= idx;
         if (take && !hwrite) hrdata_ff <= addr_ok ? rd_val : 32'h0;
         if (wr_prop) prop_en_ff <= hwdata[`FLP_PROP_W-1:0];
         if (wr_ctrl) ctrl_ff <= hwdata[`FLP_CTRL_W-1:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign fault_line_out = 1'b0;
   assign fault_line_oe = oe_ff;
   assign conv_run = run_ff;
   assign seq_off = seq_ff;
   assign hs_off = hs_ff;
   assign ls_on = ls_ff;

   // Checks
   prop_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_ff == FLP_RUN && any_fault && fault_prop) |=> fault_line_oe ##1
      (state_ff == FLP_TX_CODE))
      else $error("propagated fault did not pull the line");
   noprop_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_ff == FLP_RUN && any_fault && !fault_prop) |=>
      (!fault_line_oe && !conv_run) [*2])
      else $error("unpropagated fault touched the line");
   peer_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_ff == FLP_RUN && !any_fault && ok_fell) |-> ##[PEER_LO:PEER_HI] !conv_run)
      else $error("line fall did not turn converter off");
   code_bit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_ff == FLP_TX_CODE && cnt_ff == SLOT) |-> fault_line_oe == ~type_ff[1])
      else $error("code bit on line is wrong");
   rx_type_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_ff == FLP_RX_CODE && rx_end && rx_code != 2'h2) |=> type_ff == $past(rx_code))
      else $error("decoded type not applied");
   hiccup_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_ff == FLP_OFF_OWN && tmr_done && !lat_ff) |=> ##1 conv_run)
      else $error("no restart after hiccup");
   uv_seq_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_ff == FLP_RUN && fault_active == 5'h02 && !ctrl_ff[`FLP_CTRL_UV_CRIT])
      |=> ##1 seq_off && !hs_off)
      else $error("undervoltage not sequenced");
   emerg_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ls_on |-> hs_off && !conv_run && !seq_off)
      else $error("low side on without high side off");
   upper_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rd_ff && idx_ff == `FLP_IDX_PROP_EN) |-> hrdata[7:6] == 2'h0)
      else $error("unused enable bits read nonzero");
   en_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      wr_prop |=> prop_en_ff == $past(hwdata[5:0]))
      else $error("enable write lost");

   cov_prop: cover property (@(posedge ref_clk) disable iff (!nrst)
      state_ff == FLP_TX_CODE ##[1:100] state_ff == FLP_OFF_OWN);
   cov_peer: cover property (@(posedge ref_clk) disable iff (!nrst)
      state_ff == FLP_RX_CODE ##[1:100] state_ff == FLP_OFF_PEER);
   cov_latch: cover property (@(posedge ref_clk) disable iff (!nrst)
      state_ff == FLP_LATCHED ##1 state_ff == FLP_RUN);
endmodule

// file: flp_peer_model.sv
// Power manager and peer converters sharing the open-drain fault line
module flp_peer_model #(
   parameter int SLOT = 16,
   parameter int HOLD = 40,
   // Group of 4, 8, 16 or 32 on one line; one member sends, the rest stay idle
   parameter int MEMBERS = 4,
   parameter bit FE_EN = 1'b1,
   parameter bit BAR_EN = 1'b1
) (
   input wire logic ref_clk,
   input wire logic send,
   input wire logic [1:0] code,
   input wire logic line,
   output logic pull_low,
   output logic [1:0] rx_code,
   output logic rx_valid,
   output logic fe_off,
   output logic crowbar
);
   timeunit 1ns;
   timeprecision 1ps;
   int tx_cnt = 0;
   int rx_cnt = 0;
   logic line_q = 1'b1;
   // Start slot, two code bits, then steady low until released
   always_comb begin
      if (tx_cnt == 0 || MEMBERS < 2) pull_low = 1'b0;
      else if (tx_cnt <= SLOT) pull_low = 1'b1;
      else if (tx_cnt <= 2 * SLOT) pull_low = ~code[1];
      else if (tx_cnt <= 3 * SLOT) pull_low = ~code[0];
      else pull_low = 1'b1;
   end
   always @(posedge ref_clk) begin
      line_q <= line;
      rx_valid <= 1'b0;
      fe_off <= 1'b0;
      crowbar <= 1'b0;
      if (tx_cnt != 0) tx_cnt <= (tx_cnt == 3 * SLOT + HOLD) ? 0 : tx_cnt + 1;
      else if (send) tx_cnt <= 1;
      // Only falls made by others are decoded
      if (rx_cnt != 0) rx_cnt <= rx_cnt + 1;
      else if (line_q && !line && tx_cnt == 0) rx_cnt <= 1;
      if (rx_cnt == SLOT + SLOT / 2) rx_code[1] <= line;
      if (rx_cnt == 2 * SLOT + SLOT / 2) begin
         rx_code[0] <= line;
         rx_valid <= 1'b1;
         // Group-level fault: front end off and crowbar fire with the decode
         fe_off <= FE_EN;
         crowbar <= BAR_EN;
         rx_cnt <= 0;
      end
   end
endmodule

// file: testbench.sv
// Self-checking bench for the fault propagation block
`include "flp_defs.svh"
module testbench;
   import flp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HIC = 200;
   localparam int SLOT = `FLP_CODE_SLOT;
   localparam int LIMIT = 20000;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [`FLP_NFAULT-1:0] fault_active = 5'h00;
   logic peer_send = 1'b0;
   logic [1:0] peer_code = 2'h3;
   logic hreadyout, hresp, fault_line_out, fault_line_oe;
   logic conv_run, seq_off, hs_off, ls_on, peer_pull, rx_valid;
   logic [31:0] hrdata;
   logic [1:0] rx_code;
   logic fe_off, crowbar;
   wire fault_line;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #12.5 ref_clk = ~ref_clk;
   // Pulled up; any party pulling wins
   assign fault_line = ~(fault_line_oe | peer_pull);

   flp_top #(.HICCUP_CYCLES(32'(HIC)), .SLOT_CYC(SLOT)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fault_active(fault_active),
      .fault_line_in(fault_line), .fault_line_out(fault_line_out),
      .fault_line_oe(fault_line_oe), .conv_run(conv_run), .seq_off(seq_off),
      .hs_off(hs_off), .ls_on(ls_on));

   flp_peer_model #(.SLOT(SLOT), .HOLD(40)) peer_m (
      .ref_clk(ref_clk), .send(peer_send), .code(peer_code), .line(fault_line),
      .pull_low(peer_pull), .rx_code(rx_code), .rx_valid(rx_valid), .fe_off(fe_off),
      .crowbar(crowbar));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_fail++;
         conclude();
      end
   end

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, exp);
   endtask

   task automatic regs();
      rd_chk(32'h8, 32'h3F);
      rd_chk(32'h40, 32'h0);
      wr(32'h8, 32'hFFFFFFC0);
      rd_chk(32'h8, 32'h0);
      wr(32'h8, 32'hFF);
      rd_chk(32'h8, 32'h3F);
      wr(32'hC, 32'h0);
      rd_chk(32'hC, 32'h0);
      rd_chk(32'h8, 32'h3F);
   endtask

   // Own fault: line code, output style and restart interval
   task automatic own_fault(input int f, input logic [7:0] ctrl, input logic [1:0] code);
      int n;
      wr(32'h40, {24'h0, ctrl});
      @(posedge ref_clk);
      fault_active <= 5'(1 << f);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(conv_run, 1'b0);
      chk(fault_line_oe, 1'b1);
      chk({seq_off, hs_off, ls_on}, {code == 2'h3, code != 2'h3, code == 2'h0});
      @(posedge ref_clk);
      fault_active <= 5'h00;
      n = 1;
      while (rx_valid !== 1'b1 && n < 4 * SLOT) begin
         @(negedge ref_clk);
         n++;
      end
      chk({rx_valid, fe_off, crowbar}, 3'h7);
      chk(rx_code, code);
      while (conv_run !== 1'b1 && n < HIC + 10) begin
         @(negedge ref_clk);
         n++;
      end
      chk(n >= HIC - 2 && n <= HIC + 4, 1'b1);
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic no_prop();
      int n;
      logic seen;
      // Reserved bit left set on purpose
      wr(32'h8, 32'h3B);
      @(posedge ref_clk);
      fault_active <= 5'(1 << `FLP_F_UV);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(conv_run, 1'b0);
      @(posedge ref_clk);
      fault_active <= 5'h00;
      n = 0;
      seen = 1'b0;
      while (conv_run !== 1'b1 && n < HIC + 10) begin
         @(negedge ref_clk);
         if (fault_line_oe !== 1'b0) seen = 1'b1;
         n++;
      end
      chk(seen, 1'b0);
      chk(conv_run, 1'b1);
      wr(32'h8, 32'h3F);
   endtask

   // Latching over-current: stays off past the hiccup until cleared
   task automatic latched();
      wr(32'h40, 32'h20);
      @(posedge ref_clk);
      fault_active <= 5'(1 << `FLP_F_OC);
      @(posedge ref_clk);
      fault_active <= 5'h00;
      repeat (HIC + 20) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(conv_run, 1'b0);
      chk(fault_line_oe, 1'b1);
      wr(32'h40, 32'h120);
      repeat (2) @(negedge ref_clk);
      chk(conv_run, 1'b1);
      wr(32'h40, 32'h0);
   endtask

   // Peer pulls the line with a code; we must follow its style
   task automatic peer(input logic [1:0] code);
      int n;
      @(posedge ref_clk);
      peer_code <= code;
      peer_send <= 1'b1;
      @(posedge ref_clk);
      peer_send <= 1'b0;
      n = 0;
      while (conv_run !== 1'b0 && n < 4 * SLOT) begin
         @(negedge ref_clk);
         n++;
      end
      chk(n >= 3 * SLOT && n <= 3 * SLOT + 6, 1'b1);
      chk({seq_off, hs_off, ls_on}, {code == 2'h3, code != 2'h3, code == 2'h0});
      while (conv_run !== 1'b1 && n < 8 * SLOT) begin
         @(negedge ref_clk);
         n++;
      end
      chk(conv_run, 1'b1);
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      regs();
      own_fault(`FLP_F_OV, 8'h00, `FLP_OFF_CRIT);
      own_fault(`FLP_F_OV, 8'h04, `FLP_OFF_EMERG);
      own_fault(`FLP_F_UV, 8'h00, `FLP_OFF_SEQ);
      own_fault(`FLP_F_UV, 8'h02, `FLP_OFF_CRIT);
      own_fault(`FLP_F_OT, 8'h00, `FLP_OFF_SEQ);
      own_fault(`FLP_F_OT, 8'h01, `FLP_OFF_CRIT);
      own_fault(`FLP_F_OC, 8'h00, `FLP_OFF_CRIT);
      own_fault(`FLP_F_TR, 8'h00, `FLP_OFF_CRIT);
      no_prop();
      latched();
      peer(`FLP_OFF_EMERG);
      peer(`FLP_OFF_CRIT);
      peer(`FLP_OFF_SEQ);
      conclude();
   end
endmodule
